/* File: verilog/mfc_top.sv */
// What this block does
// - Level bit picks 3.3V or 5V reference thresholds.
// - Mode bit makes reference events warnings or faults.
// - Deglitch bit adds 1us filter before phase pin.
// - Report mode also drives secondary fault pin low.
// - Comparator disabled means phase outputs and status invalid.
// - Buffer enable drives pins and forces low-side inputs.
// - Threshold bit picks 75/25 or 50 percent.
// - Single mode pulls faulty bridge, faults when all.
// - All-channel mode stops all, faults, clears enable.
// - High-side drain threshold at bits 7-4, reset B.
// - Low-side drain threshold at bits 3-0, same coding.
`timescale 1ns/1ps
`default_nettype none
module mfc_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Register port from the serial interface logic.
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_err,
  // Fault clear and driver enable handshake.
  input wire logic fault_clear_bit,
  input wire logic driver_enable_bit,
  output logic driver_enable_clear,
  // Monitor events, already in this clock domain.
  input wire mfc_pkg::mfc_fault_t fault_in,
  input wire logic ref_uv_event,
  input wire logic ref_ov_event,
  input wire logic [2:0] phase_fault_event,
  // Raw analog comparator results.
  input wire logic [2:0] phase_comp_raw,
  // Low-side PWM pins and their gated copies.
  input wire logic [2:0] low_side_pwm_input,
  output logic [2:0] low_side_pwm_gated,
  // Settings handed to the analog monitors.
  output mfc_pkg::mfc_thresh_t thresh,
  output logic phase_comp_on,
  // Monitor results.
  output logic ref_warning,
  output logic ref_fault,
  output logic [2:0] phase_status,
  output logic phase_valid,
  // Half-bridge shutdown controls.
  output logic [2:0] hb_pulldown,
  output logic hb_semi_active,
  // Open-drain and three-state pins, enable low while driving.
  output logic [2:0] phase_out_pin_o,
  output logic [2:0] phase_out_pin_oe_n,
  output logic fault_pin_n_o,
  output logic fault_pin_n_oe_n,
  output logic secondary_fault_pin_n_o,
  output logic secondary_fault_pin_n_oe_n
);
  import mfc_pkg::*;

  // Stored register contents.
  logic [15:0] ref_phase_reg;
  logic [15:0] ch_shut_reg;
  // Synchronised copies of pin inputs.
  logic [2:0] comp_s1_reg, comp_s2_reg;
  logic [2:0] pwm_s1_reg, pwm_s2_reg;
  // Filtered comparator result.
  logic [2:0] comp_filt_reg;
  // Settle timer state.
  mfc_ph_state_t ph_state_reg;
  logic [MFC_CNT_W-1:0] settle_cnt_reg;
  // Latched per-channel protection faults.
  logic [2:0] ch_fault_reg;
  logic [2:0] ch_fault_next;

  // Decodes an address into the stored value it reads.
  function automatic logic [15:0] mfc_read(input logic [7:0] a, input logic [15:0] r5,
                                           input logic [15:0] r6);
    if (a == MFC_ADDR_REF_PHASE) begin
      mfc_read = r5;
    end else if (a == MFC_ADDR_CH_SHUT) begin
      mfc_read = r6;
    end else begin
      mfc_read = 16'h0000;
    end
  endfunction

  // Field aliases for readability.
  logic ph_en, ph_buf, ph_dg, ph_mode, ref_mode, all_channel_shutdown;
  assign ph_en = ref_phase_reg[MFC_BIT_PH_EN];
  assign ph_buf = ref_phase_reg[MFC_BIT_PH_BUF];
  assign ph_dg = ref_phase_reg[MFC_BIT_PH_DG];
  assign ph_mode = ref_phase_reg[MFC_BIT_PH_MODE];
  assign ref_mode = ref_phase_reg[MFC_BIT_REF_MODE];
  assign all_channel_shutdown = ch_shut_reg[MFC_BIT_ALL_CHANNEL_SHUTDOWN];

  // Register writes; only writable bits are stored.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ref_phase_reg <= MFC_RST_REF_PHASE;
      ch_shut_reg <= MFC_RST_CH_SHUT;
    end else if (reg_wr) begin
      if (reg_addr == MFC_ADDR_REF_PHASE) begin
        ref_phase_reg <= reg_wdata & MFC_MASK_REF_PHASE;
      end else if (reg_addr == MFC_ADDR_CH_SHUT) begin
        ch_shut_reg <= reg_wdata & MFC_MASK_CH_SHUT;
      end
    end
  end

  // Register reads answer one cycle later; other addresses flag an error.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
      reg_err <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= mfc_read(reg_addr, ref_phase_reg, ch_shut_reg);
        reg_err <= (reg_addr != MFC_ADDR_REF_PHASE) && (reg_addr != MFC_ADDR_CH_SHUT);
      end else begin
        reg_err <= 1'b0;
      end
    end
  end

  // Threshold settings to the analog monitors.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      thresh <= '0;
      phase_comp_on <= 1'b0;
    end else begin
      thresh.sdo_level <= ref_phase_reg[MFC_BIT_SDO_LVL];
      thresh.ref_level <= ref_phase_reg[MFC_BIT_REF_LVL];
      thresh.phase_threshold <= ref_phase_reg[MFC_BIT_PH_TH];
      thresh.high_side_drain_threshold <= ch_shut_reg[MFC_HS_MSB:MFC_HS_LSB];
      thresh.low_side_drain_threshold <= ch_shut_reg[MFC_LS_MSB:MFC_LS_LSB];
      phase_comp_on <= ph_en;
    end
  end

  // Reference monitor: events become warnings or faults, cleared by fault clear.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ref_warning <= 1'b0;
      ref_fault <= 1'b0;
    end else begin
      // warning or fault mode, set wins over clear.
      if ((ref_uv_event || ref_ov_event) && !ref_mode) begin
        ref_warning <= 1'b1;
      end else if (fault_clear_bit) begin
        ref_warning <= 1'b0;
      end
      if ((ref_uv_event || ref_ov_event) && ref_mode) begin
        ref_fault <= 1'b1;
      end else if (fault_clear_bit) begin
        ref_fault <= 1'b0;
      end
    end
  end

  // Two-stage synchronisers for comparator and PWM pins.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      comp_s1_reg <= 3'h0;
      comp_s2_reg <= 3'h0;
      pwm_s1_reg <= 3'h0;
      pwm_s2_reg <= 3'h0;
    end else begin
      comp_s1_reg <= phase_comp_raw;
      comp_s2_reg <= comp_s1_reg;
      pwm_s1_reg <= low_side_pwm_input;
      pwm_s2_reg <= pwm_s1_reg;
    end
  end

  // Per-channel deglitch filter: the output follows only a stable input.
  generate
    for (genvar i = 0; i < MFC_NCH; i++) begin : g_dg
      logic [MFC_CNT_W-1:0] dg_cnt_reg;
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          dg_cnt_reg <= '0;
          comp_filt_reg[i] <= 1'b0;
        end else if (!ph_dg || comp_s2_reg[i] == comp_filt_reg[i]) begin
          dg_cnt_reg <= '0;
          comp_filt_reg[i] <= comp_s2_reg[i];
        end else if (dg_cnt_reg == MFC_CNT_W'(MFC_DEGLITCH_CYC - 1)) begin
          dg_cnt_reg <= '0;
          comp_filt_reg[i] <= comp_s2_reg[i];
        end else begin
          dg_cnt_reg <= dg_cnt_reg + MFC_CNT_W'(1);
        end
      end
    end
  endgenerate

  // Settle timer after comparator enable; disable returns to off at once.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ph_state_reg <= MFC_PH_OFF;
      settle_cnt_reg <= '0;
    end else begin
      case (ph_state_reg)
        MFC_PH_OFF: begin
          settle_cnt_reg <= '0;
          if (ph_en) begin
            ph_state_reg <= MFC_PH_SETTLE;
          end
        end
        MFC_PH_SETTLE: begin
          if (!ph_en) begin
            ph_state_reg <= MFC_PH_OFF;
          end else if (settle_cnt_reg == MFC_CNT_W'(MFC_SETTLE_CYC - 1)) begin
            ph_state_reg <= MFC_PH_READY;
          end else begin
            settle_cnt_reg <= settle_cnt_reg + MFC_CNT_W'(1);
          end
        end
        MFC_PH_READY: begin
          if (!ph_en) begin
            ph_state_reg <= MFC_PH_OFF;
          end
        end
        default: begin
          ph_state_reg <= MFC_PH_OFF;
        end
      endcase
    end
  end

  // Phase status and pins; everything is held invalid while disabled.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_status <= 3'h0;
      phase_valid <= 1'b0;
      phase_out_pin_o <= 3'h0;
      phase_out_pin_oe_n <= 3'h7;
      secondary_fault_pin_n_o <= 1'b1;
      secondary_fault_pin_n_oe_n <= 1'b1;
    end else begin
      phase_valid <= (ph_state_reg == MFC_PH_READY) && ph_en;
      if (!ph_en) begin
        phase_status <= 3'h0;
      end else if (ph_state_reg == MFC_PH_READY) begin
        phase_status <= phase_status | phase_fault_event;
      end else if (fault_clear_bit) begin
        phase_status <= 3'h0;
      end
      if (fault_clear_bit && ph_en && ph_state_reg == MFC_PH_READY) begin
        phase_status <= phase_fault_event;
      end
      phase_out_pin_o <= (ph_buf && ph_en) ? comp_filt_reg : 3'h0;
      phase_out_pin_oe_n <= ph_buf ? 3'h0 : 3'h7;
      secondary_fault_pin_n_o <= 1'b0;
      secondary_fault_pin_n_oe_n <= !(ph_mode && ph_en && (|phase_status));
    end
  end

  // Low-side PWM inputs are forced low while the phase buffer is on.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_side_pwm_gated <= 3'h0;
    end else begin
      low_side_pwm_gated <= ph_buf ? 3'h0 : pwm_s2_reg;
    end
  end

  // Next channel fault latch; a new fault wins over a clear.
  always_comb begin
    ch_fault_next = ch_fault_reg;
    if (fault_clear_bit) begin
      ch_fault_next = 3'h0;
    end
    ch_fault_next = ch_fault_next | fault_in.drain | fault_in.gate | fault_in.shunt;
  end

  // Shutdown policy for protection faults.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ch_fault_reg <= 3'h0;
      hb_pulldown <= 3'h0;
      hb_semi_active <= 1'b0;
      fault_pin_n_o <= 1'b1;
      fault_pin_n_oe_n <= 1'b1;
      driver_enable_clear <= 1'b0;
    end else begin
      ch_fault_reg <= ch_fault_next;
      fault_pin_n_o <= 1'b0;
      if (all_channel_shutdown) begin
        hb_pulldown <= (|ch_fault_next) ? 3'h7 : 3'h0;
        hb_semi_active <= |ch_fault_next;
        fault_pin_n_oe_n <= !(|ch_fault_next);
        driver_enable_clear <= (|ch_fault_next) && driver_enable_bit;
      end else begin
        hb_pulldown <= ch_fault_next;
        hb_semi_active <= 1'b0;
        fault_pin_n_oe_n <= !(&ch_fault_next);
        driver_enable_clear <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verilog/mfc_pkg.sv */
`default_nettype none
// Shared constants and carriers for the monitor and fault configuration block.
package mfc_pkg;
  // Register addresses on the configuration port.
  localparam logic [7:0] MFC_ADDR_REF_PHASE = 8'h2F;
  localparam logic [7:0] MFC_ADDR_CH_SHUT = 8'h30;
  // Reset values of both registers.
  localparam logic [15:0] MFC_RST_REF_PHASE = 16'h0000;
  localparam logic [15:0] MFC_RST_CH_SHUT = 16'h20BB;
  // Writable bit masks; every other bit is reserved and reads as zero.
  localparam logic [15:0] MFC_MASK_REF_PHASE = 16'h381F;
  localparam logic [15:0] MFC_MASK_CH_SHUT = 16'h20FF;
  // Field positions in the reference and phase register.
  localparam int MFC_BIT_SDO_LVL = 13;
  localparam int MFC_BIT_REF_LVL = 12;
  localparam int MFC_BIT_REF_MODE = 11;
  localparam int MFC_BIT_PH_DG = 4;
  localparam int MFC_BIT_PH_MODE = 3;
  localparam int MFC_BIT_PH_EN = 2;
  localparam int MFC_BIT_PH_BUF = 1;
  localparam int MFC_BIT_PH_TH = 0;
  // Field positions in the channel shutdown register.
  localparam int MFC_BIT_ALL_CHANNEL_SHUTDOWN = 13;
  localparam int MFC_HS_MSB = 7;
  localparam int MFC_HS_LSB = 4;
  localparam int MFC_LS_MSB = 3;
  localparam int MFC_LS_LSB = 0;
  // Timing figures and their cycle counts at the core clock.
  localparam int MFC_CLK_HZ = 10_000_000;
  localparam int MFC_DEGLITCH_NS = 1000;
  localparam int MFC_SETTLE_NS = 5000;
  localparam int MFC_DEGLITCH_CYC = (MFC_DEGLITCH_NS * (MFC_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int MFC_SETTLE_CYC = (MFC_SETTLE_NS * (MFC_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int MFC_CNT_W = 8;
  // Number of half-bridge channels.
  localparam int MFC_NCH = 3;
  // Per-channel fault events from the protection monitors.
  typedef struct packed {
    logic [2:0] drain;
    logic [2:0] gate;
    logic [2:0] shunt;
  } mfc_fault_t;
  // Decoded threshold selections handed to the analog monitors.
  typedef struct packed {
    logic sdo_level;
    logic ref_level;
    logic phase_threshold;
    logic [3:0] high_side_drain_threshold;
    logic [3:0] low_side_drain_threshold;
  } mfc_thresh_t;
  // Phase comparator enable states.
  typedef enum logic [2:0] {
    MFC_PH_OFF = 3'b001,
    MFC_PH_SETTLE = 3'b010,
    MFC_PH_READY = 3'b100
  } mfc_ph_state_t;
endpackage
`default_nettype wire

/* File: test/mfc_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module mfc_top_properties (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Register port.
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_err,
  // Outputs under watch.
  input wire logic driver_enable_clear,
  input wire logic [2:0] low_side_pwm_gated,
  input wire mfc_pkg::mfc_thresh_t thresh,
  input wire logic phase_comp_on,
  input wire logic [2:0] phase_status,
  input wire logic phase_valid,
  input wire logic [2:0] hb_pulldown,
  input wire logic hb_semi_active,
  input wire logic [2:0] phase_out_pin_oe_n,
  input wire logic fault_pin_n_oe_n,
  input wire logic secondary_fault_pin_n_oe_n
);
  import mfc_pkg::*;
  // All checks share the core clock and its reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  read_answer_a: assert property (reg_rd |=> reg_rvalid && reg_err ==
    ($past(reg_addr) != MFC_ADDR_REF_PHASE && $past(reg_addr) != MFC_ADDR_CH_SHUT))
    else $error("Read answer or error flag wrong.");
  reserved_zero_a: assert property (reg_rd |=> (reg_rdata & ~(($past(reg_addr) ==
    MFC_ADDR_CH_SHUT) ? 16'h20FF : 16'h381F)) == 16'h0000)
    else $error("Reserved bit read back set.");
  drain_copy_a: assert property (reg_wr && reg_addr == MFC_ADDR_CH_SHUT |-> ##2
    {thresh.high_side_drain_threshold, thresh.low_side_drain_threshold} ==
    $past(reg_wdata[7:0], 2))
    else $error("Drain thresholds not taken from write.");
  ref_copy_a: assert property (reg_wr && reg_addr == MFC_ADDR_REF_PHASE |-> ##2
    {thresh.ref_level, thresh.phase_threshold} ==
    {$past(reg_wdata[12], 2), $past(reg_wdata[0], 2)})
    else $error("Reference or phase threshold not taken from write.");
  disabled_invalid_a: assert property (!phase_comp_on && $past(!phase_comp_on) |->
    !phase_valid && phase_status == 3'h0) else $error("Phase result valid while disabled.");
  settle_hold_a: assert property ($rose(phase_comp_on) |-> !phase_valid [*8])
    else $error("Phase result valid too early.");
  buffer_force_a: assert property (phase_out_pin_oe_n == 3'h0 &&
    $past(phase_out_pin_oe_n) == 3'h0 |-> low_side_pwm_gated == 3'h0)
    else $error("Low-side inputs pass while buffer drives.");
  all_channel_a: assert property (hb_semi_active && hb_pulldown != 3'h0 |->
    hb_pulldown == 3'h7 && !fault_pin_n_oe_n) else $error("All-channel shutdown incomplete.");
  single_channel_a: assert property (!hb_semi_active && hb_pulldown != 3'h7 &&
    $past(hb_pulldown) != 3'h7 |-> fault_pin_n_oe_n && !driver_enable_clear)
    else $error("Single-channel mode reported too early.");
  sec_pin_idle_a: assert property (phase_status == 3'h0 |=> secondary_fault_pin_n_oe_n)
    else $error("Secondary fault pin low without status.");
endmodule
bind mfc_top mfc_top_properties mfc_top_properties_inst (.*);
`default_nettype wire

/* File: test/mfc_mcu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mfc_mcu_model (
  // Clock.
  input wire logic clk,
  // Device pins.
  input wire logic fault_pin_n_o,
  input wire logic fault_pin_n_oe_n,
  input wire logic secondary_fault_pin_n_o,
  input wire logic secondary_fault_pin_n_oe_n,
  input wire logic [2:0] phase_out_pin_o,
  input wire logic [2:0] phase_out_pin_oe_n,
  // Levels seen by the controller.
  output logic fault_line,
  output logic sec_line,
  output logic [2:0] phase_line
);
  // Pattern shown by released phase pins, so no stale level is read.
  logic [2:0] float_pat = 3'h5;
  // The pattern changes every cycle.
  always @(posedge clk) float_pat <= ~float_pat;
  assign phase_line = (~phase_out_pin_oe_n & phase_out_pin_o) | (phase_out_pin_oe_n & float_pat);
  assign fault_line = fault_pin_n_oe_n ? 1'b1 : fault_pin_n_o;
  assign sec_line = secondary_fault_pin_n_oe_n ? 1'b1 : secondary_fault_pin_n_o;
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
  $display("Error at %0t ns: got %0h, expected %0h", $time, (a), (b)); end end
module tb_top;
  import mfc_pkg::*;
  // Stimulus, all given a value at time zero.
  logic clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, fault_clear_bit = 0, driver_enable_bit = 0;
  logic ref_uv_event = 0, ref_ov_event = 0;
  logic [7:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0;
  logic [2:0] phase_fault_event = 0, phase_comp_raw = 0, low_side_pwm_input = 0;
  mfc_fault_t fault_in = '0;
  // Design outputs and controller-side levels.
  logic [15:0] reg_rdata;
  logic reg_rvalid, reg_err, driver_enable_clear, phase_comp_on, ref_warning, ref_fault;
  logic phase_valid, hb_semi_active, fault_pin_n_o, fault_pin_n_oe_n;
  logic secondary_fault_pin_n_o, secondary_fault_pin_n_oe_n, fault_line, sec_line;
  logic [2:0] low_side_pwm_gated, phase_status, hb_pulldown, phase_out_pin_o, phase_out_pin_oe_n;
  logic [2:0] phase_line;
  mfc_thresh_t thresh;
  int fails = 0, cmp_count = 0, cycles = 0;
  mfc_top mfc_top_inst (.*);
  mfc_mcu_model mfc_mcu_model_inst (.*);
  // Clock of 100 ns period.
  initial forever #50 clk = ~clk;
  // Prints the counts and the verdict, then stops.
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // A hang counts as a mismatch.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      final_report();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) begin reg_wr <= 1; reg_addr <= a; reg_wdata <= d; end
    @(posedge clk) reg_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic er);
    @(posedge clk) begin reg_rd <= 1; reg_addr <= a; end
    @(posedge clk) reg_rd <= 0;
    #1;
    `CHK(reg_rvalid, 1'b1)
    `CHK(reg_err, er)
    `CHK(reg_rdata, e)
  endtask
  // One-cycle pulse of fault events, sampled after the answer lands.
  task automatic flt(input mfc_fault_t f);
    @(posedge clk) fault_in <= f;
    @(posedge clk) fault_in <= '0;
    #1;
  endtask
  task automatic clr;
    @(posedge clk) fault_clear_bit <= 1;
    @(posedge clk) fault_clear_bit <= 0;
    cyc(1);
  endtask
  // Main sequence; reset held for four cycles.
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1;
    rd(8'h30, 16'h20BB, 0);
    rd(8'h2F, 16'h0000, 0);
    `CHK(thresh.high_side_drain_threshold, 4'hB)
    wr(8'h2F, 16'hFFFF);
    wr(8'h30, 16'hFFFF);
    wr(8'h31, 16'h1234);
    rd(8'h2F, 16'h381F, 0);
    `CHK(thresh.sdo_level, 1'b1)
    rd(8'h30, 16'h20FF, 0);
    rd(8'h31, 16'h0000, 1);
    wr(8'h30, 16'h20A5);
    cyc(2);
    `CHK(thresh.high_side_drain_threshold, 4'hA)
    `CHK(thresh.low_side_drain_threshold, 4'h5)
    wr(8'h2F, 16'h1000);
    cyc(2);
    `CHK(thresh.ref_level, 1'b1)
    wr(8'h2F, 16'h0001);
    cyc(2);
    `CHK(thresh.phase_threshold, 1'b1)
    `CHK(thresh.ref_level, 1'b0)
    $display("Test registers finished");
    @(posedge clk) driver_enable_bit <= 1;
    flt(9'h040);
    `CHK(hb_pulldown, 3'h7)
    `CHK(hb_semi_active, 1'b1)
    `CHK(fault_line, 1'b0)
    `CHK(driver_enable_clear, 1'b1)
    clr();
    `CHK(hb_pulldown, 3'h0)
    wr(8'h30, 16'h00A5);
    flt(9'h040);
    `CHK(hb_pulldown, 3'h1)
    `CHK(hb_semi_active, 1'b0)
    `CHK(fault_line, 1'b1)
    flt(9'h014);
    cyc(1);
    `CHK(hb_pulldown, 3'h7)
    `CHK(fault_line, 1'b0)
    `CHK(driver_enable_clear, 1'b0)
    // clear with enable dropped, then enable again
    @(posedge clk) begin fault_clear_bit <= 1; driver_enable_bit <= 0; end
    @(posedge clk) fault_clear_bit <= 0;
    @(posedge clk) driver_enable_bit <= 1;
    cyc(2);
    `CHK(hb_pulldown, 3'h0)
    `CHK(fault_line, 1'b1)
    $display("Test shutdown finished");
    @(posedge clk) begin phase_comp_raw <= 3'h5; low_side_pwm_input <= 3'h7; end
    wr(8'h2F, 16'h000E);
    cyc(2);
    `CHK(phase_valid, 1'b0)
    `CHK(phase_comp_on, 1'b1)
    `CHK(phase_out_pin_oe_n, 3'h0)
    `CHK(low_side_pwm_gated, 3'h0)
    // wait well past the settle time before trusting results
    cyc(60);
    `CHK(phase_valid, 1'b1)
    `CHK(phase_line, 3'h5)
    @(posedge clk) phase_fault_event <= 3'h2;
    @(posedge clk) phase_fault_event <= 3'h0;
    cyc(2);
    `CHK(phase_status, 3'h2)
    `CHK(sec_line, 1'b0)
    `CHK(hb_pulldown, 3'h0)
    wr(8'h2F, 16'h001E);
    @(posedge clk) phase_comp_raw <= 3'h2;
    cyc(6);
    `CHK(phase_line, 3'h5)
    cyc(14);
    `CHK(phase_line, 3'h2)
    wr(8'h2F, 16'h0016);
    cyc(2);
    `CHK(sec_line, 1'b1)
    `CHK(phase_status, 3'h2)
    wr(8'h2F, 16'h0000);
    cyc(3);
    `CHK(phase_comp_on, 1'b0)
    `CHK(phase_valid, 1'b0)
    `CHK(phase_status, 3'h0)
    `CHK(phase_out_pin_oe_n, 3'h7)
    `CHK(low_side_pwm_gated, 3'h7)
    $display("Test phase finished");
    @(posedge clk) ref_uv_event <= 1;
    @(posedge clk) ref_uv_event <= 0;
    cyc(1);
    `CHK(ref_warning, 1'b1)
    `CHK(ref_fault, 1'b0)
    clr();
    `CHK(ref_warning, 1'b0)
    wr(8'h2F, 16'h0800);
    @(posedge clk) ref_ov_event <= 1;
    @(posedge clk) ref_ov_event <= 0;
    cyc(1);
    `CHK(ref_fault, 1'b1)
    $display("Test reference finished");
    final_report();
  end
endmodule
`default_nettype wire
